// ---- hdl/sar_adc_ctrl.sv ----
// Conversion sequencing and serial readout control of a SAR converter
//
// Notes on behaviour
// - In three-wire use convert_start_pin acts as active-low chip select too.
// - Serial-input level at conversion start chooses chip-select or daisy-chain mode.
// - In four-wire use the serial-input pin is the active-low chip select.
// - Result bits move out only in step with the host serial clock.
// - Conversion start captures the input sample and holds it throughout.
// - Analog inputs stay isolated from the sampling circuit while converting.
// - Conversion is timed by the internal clock, never the serial clock.
// - After conversion, sampling capacitors reconnect and acquisition begins.
// - Acquisition is powered down yet the result can be read then.
// - Result is presented in SPI-compatible serial form, host is clock master.
// - Serial input high at convert rise selects chip-select mode, else daisy-chain.
// - Convert rising edge tri-states output, samples input, enters conversion.
// - Chip select fall drives the MSB, later bits on serial clock falls.
// - Output tri-states after the 18th serial clock fall or chip select high.
`timescale 1ns/1ns
module sar_adc_ctrl
   import sar_ctrl_pkg::*;
#(
   parameter int CONV_LEN = CONV_CYCLES
) (
   input  wire logic                   sys_clk_i,
   input  wire logic                   reset_i,
   input  wire logic                   serial_clk_i,
   input  wire logic                   convert_start_pin_i,
   input  wire logic                   serial_in_i,
   input  wire logic [RESULT_BITS-1:0] sample_code_i,
   output logic                        dout_o,
   output logic                        dout_oe_o,
   output logic                        input_connect_o,
   output logic                        converting_o,
   output logic                        power_down_o,
   output logic                        cs_mode_o
);

   // ----------------------------------------------------------------------
   // Link side: count serial clock falling edges within a frame
   // ----------------------------------------------------------------------
   // Select is low while either candidate line is low: in three-wire use the
   // serial input is tied high, in four-wire use convert_start stays high.
   logic             cs_n_pin;
   logic [IDX_W-1:0] fall_cnt_r;
   logic [IDX_W-1:0] fall_gray_r;
   logic [IDX_W-1:0] fall_cnt_nxt;

   assign cs_n_pin     = convert_start_pin_i & serial_in_i;
   assign fall_cnt_nxt = (fall_cnt_r == READ_BITS) ? fall_cnt_r : fall_cnt_r + 5'h01;

   // The serial clock stands still between frames, so the frame's own select
   // clears the count rather than an edge that may never come.
   always_ff @(negedge serial_clk_i or posedge cs_n_pin) begin
      if (cs_n_pin) begin
         fall_cnt_r  <= 5'h00;
         fall_gray_r <= 5'h00;
      end else begin
         fall_cnt_r  <= fall_cnt_nxt;
         fall_gray_r <= bin_to_gray(fall_cnt_nxt);
      end
   end

   // ----------------------------------------------------------------------
   // Crossings into sys_clk_i
   // ----------------------------------------------------------------------
   logic [1:0]       pins_s;
   logic [IDX_W-1:0] fall_gray_s;
   logic             cnv_s;
   logic             din_s;
   logic             cs_n_s;
   logic [IDX_W-1:0] bit_idx;

   // Both pins idle high
   bit_sync #(
      .WIDTH     (2),
      .RESET_VAL (2'h3)
   ) u_pin_sync (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .async_i   ({convert_start_pin_i, serial_in_i}),
      .sync_o    (pins_s)
   );

   bit_sync #(
      .WIDTH (IDX_W)
   ) u_idx_sync (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .async_i   (fall_gray_r),
      .sync_o    (fall_gray_s)
   );

   assign cnv_s   = pins_s[1];
   assign din_s   = pins_s[0];
   assign cs_n_s  = cnv_s & din_s;
   assign bit_idx = gray_to_bin(fall_gray_s);

   // ----------------------------------------------------------------------
   // Conversion sequencing
   // ----------------------------------------------------------------------
   logic                   cnv_d_r;
   logic                   start;
   logic                   conv_done;
   phase_e                 phase_r;
   phase_e                 phase_nxt;
   logic [CONV_CNT_W-1:0]  conv_cnt_r;
   logic [RESULT_BITS-1:0] held_code_r;
   logic [RESULT_BITS-1:0] result_r;
   logic                   data_ready_r;

   // Start is taken only while acquiring; a rise during a conversion is lost
   assign start     = cnv_s & ~cnv_d_r & (phase_r == ST_ACQUIRE);
   assign conv_done = (phase_r == ST_CONVERT) &&
                      (conv_cnt_r == CONV_CNT_W'(CONV_LEN - 1));

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         cnv_d_r <= 1'b1;
      end else begin
         cnv_d_r <= cnv_s;
      end
   end

   always_comb begin
      phase_nxt = phase_r;
      unique case (phase_r)
         ST_ACQUIRE: begin
            if (start) begin
               phase_nxt = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            phase_nxt = ST_CONVERT;
         end
         ST_CONVERT: begin
            if (conv_done) begin
               phase_nxt = ST_ACQUIRE;
            end
         end
         default: begin
            phase_nxt = ST_ACQUIRE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         phase_r <= ST_ACQUIRE;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // Internal clock only; the serial clock plays no part in conversion time
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || phase_r != ST_CONVERT) begin
         conv_cnt_r <= '0;
      end else begin
         conv_cnt_r <= conv_cnt_r + 8'h01;
      end
   end

   // Sample on the start, then hold; input changes while converting are ignored
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         held_code_r <= RESULT_RST;
      end else if (phase_r == ST_SAMPLE) begin
         held_code_r <= sample_code_i;
      end
   end

   // Result is quasi-static while readable: it changes only at conversion
   // end, when no frame may run, so the link needs no copy of its own.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         result_r <= RESULT_RST;
      end else if (conv_done) begin
         result_r <= held_code_r;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i || start) begin
         data_ready_r <= 1'b0;
      end else if (conv_done) begin
         data_ready_r <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         cs_mode_o <= 1'b1;
      end else if (start) begin
         cs_mode_o <= din_s;
      end
   end

   // ----------------------------------------------------------------------
   // Analog switch and power state
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         input_connect_o <= 1'b1;
         converting_o    <= 1'b0;
         power_down_o    <= 1'b1;
      end else begin
         input_connect_o <= (phase_nxt == ST_ACQUIRE);
         converting_o    <= (phase_nxt != ST_ACQUIRE);
         power_down_o    <= (phase_nxt == ST_ACQUIRE);
      end
   end

   // ----------------------------------------------------------------------
   // Serial output
   // ----------------------------------------------------------------------
   // Daisy-chain framing is not modelled: in that mode the output stays off.
   logic read_en;

   assign read_en = cs_mode_o & data_ready_r & (phase_r == ST_ACQUIRE) & ~start &
                    ~cs_n_s & (bit_idx < READ_BITS);

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         dout_oe_o <= 1'b0;
      end else begin
         dout_oe_o <= read_en;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         dout_o <= 1'b0;
      end else if (read_en) begin
         dout_o <= result_r[MSB_INDEX - bit_idx];
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   localparam int CONV_WAIT = CONV_LEN - 1;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   conv_length_a: assert property ($rose(phase_r == ST_CONVERT) |->
      ##CONV_WAIT conv_done ##1 phase_r == ST_ACQUIRE)
      else $error("conversion length differs from the programmed count");
   conv_bound_a: assert property (phase_r == ST_CONVERT |->
      conv_cnt_r < CONV_CNT_W'(CONV_LEN))
      else $error("conversion counter ran past its count");
   mode_latch_a: assert property (start |=> cs_mode_o == $past(din_s))
      else $error("mode not taken from serial input at start");
   start_hiz_a: assert property (start |=> !dout_oe_o ##1 converting_o)
      else $error("output not off or conversion not entered after start");
   isolate_a: assert property (converting_o |-> !input_connect_o)
      else $error("inputs connected during conversion");
   hold_a: assert property (phase_r == ST_CONVERT |=> $stable(held_code_r))
      else $error("held sample changed during conversion");
   reconnect_a: assert property (conv_done |=> input_connect_o && power_down_o)
      else $error("acquisition not entered after conversion");
   read_acq_a: assert property (dout_oe_o |-> power_down_o && cs_mode_o)
      else $error("output driven outside acquisition");
   msb_first_a: assert property (read_en && bit_idx == 5'h00 |=>
      dout_oe_o && dout_o == result_r[MSB_INDEX])
      else $error("first bit of a frame is not the MSB");
   select_on_a: assert property (!cnv_s && din_s && cs_mode_o && data_ready_r &&
      phase_r == ST_ACQUIRE && !start && bit_idx < READ_BITS |=> dout_oe_o)
      else $error("selected frame did not enable the output");
   tri_end_a: assert property (cs_n_s || bit_idx == READ_BITS |=> !dout_oe_o)
      else $error("output still driven after frame end");

   cs_frame_c: cover property (read_en ##[1:1000] bit_idx == READ_BITS);
   abort_c: cover property (dout_oe_o && bit_idx < READ_BITS ##1 cs_n_s);
   daisy_c: cover property (start && !din_s);
   busy_start_c: cover property (phase_r == ST_CONVERT && cnv_s && !cnv_d_r);

endmodule

// ---- include/sar_ctrl_pkg.sv ----
// Constants and types shared by the converter control and readout logic
package sar_ctrl_pkg;

   // ----------------------------------------------------------------------
   // Result format
   // ----------------------------------------------------------------------
   localparam int          RESULT_BITS = 18;
   localparam int          IDX_W       = 5;
   localparam logic [4:0]  READ_BITS   = 5'h12;
   localparam logic [4:0]  MSB_INDEX   = 5'h11;
   localparam logic [17:0] RESULT_RST  = 18'h00000;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int SYS_CLK_PERIOD_NS = 8;
   localparam int T_CONV_MIN_NS     = 500;
   localparam int T_CONV_MAX_NS     = 710;
   // The host may read once the longest conversion has elapsed, so the
   // modelled conversion must not exceed it: round down.
   localparam int CONV_CYCLES       = T_CONV_MAX_NS / SYS_CLK_PERIOD_NS;
   localparam int CONV_CNT_W        = 8;
   localparam int SYNC_STAGES       = 2;

   // ----------------------------------------------------------------------
   // Phases of one conversion cycle (Gray along acquire -> sample -> convert)
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_ACQUIRE = 2'b00,
      ST_SAMPLE  = 2'b01,
      ST_CONVERT = 2'b11
   } phase_e;

   function automatic logic [4:0] bin_to_gray(input logic [4:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [4:0] gray_to_bin(input logic [4:0] g);
      logic [4:0] b;
      b[4] = g[4];
      for (int i = 3; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

endpackage

// ---- hdl/bit_sync.sv ----
// Two-stage synchroniser for levels and Gray-coded words entering sys_clk_i
`timescale 1ns/1ns
module bit_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             sys_clk_i,
   input  wire logic             reset_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage. Reset loads the idle level of
   // the source, so that no false edge is seen once reset lets go.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         meta_r <= RESET_VAL;
         sync_o <= RESET_VAL;
      end else begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end

endmodule

// ---- dv/spi_host_model.sv ----
// Serial host model: drives convert start, serial input and serial clock
`timescale 1ns/1ns
module spi_host_model (
   output logic cnv_o,
   output logic din_o,
   output logic sclk_o,
   input  wire logic dout_i,
   input  wire logic dout_oe_i
);
   // -----------------------------------------------------------------
   // Pins idle high; the serial clock stands still between frames
   // -----------------------------------------------------------------
   initial begin
      cnv_o  = 1'b1;
      din_o  = 1'b1;
      sclk_o = 1'b1;
   end

   // Mode level is set well before the rising edge and held after it
   task automatic start(input logic din_lvl);
      din_o = din_lvl;
      cnv_o = 1'b0;
      #24 cnv_o = 1'b1;
   endtask

   task automatic deselect();
      din_o = 1'b1;
   endtask

   // Bits are taken just before each falling edge; a disabled output reads X
   task automatic frame(input logic three_wire, input int nbits, output logic [17:0] data);
      data = {18{1'bx}};
      if (three_wire) cnv_o = 1'b0;
      else din_o = 1'b0;
      for (int k = 0; k < nbits; k++) begin
         #62 data[17-k] = dout_oe_i ? dout_i : 1'bx;
         sclk_o = 1'b0;
         #63 sclk_o = 1'b1;
      end
   endtask
endmodule

// ---- dv/test_sar_adc_ctrl.sv ----
// Self-checking bench for conversion sequencing and serial readout
`timescale 1ns/1ns
module test_sar_adc_ctrl;
   import sar_ctrl_pkg::*;
   localparam int CONV_LEN_TB = 10;
   logic                   sys_clk;
   logic                   reset;
   logic [RESULT_BITS-1:0] sample_code;
   logic                   cnv, din, sclk, dout, dout_oe;
   logic                   input_connect, converting, power_down, cs_mode;
   logic [17:0]            d;
   int                     error_cnt;
   int                     checked;

   sar_adc_ctrl #(.CONV_LEN(CONV_LEN_TB)) dut (
      .sys_clk_i(sys_clk), .reset_i(reset), .serial_clk_i(sclk),
      .convert_start_pin_i(cnv), .serial_in_i(din), .sample_code_i(sample_code),
      .dout_o(dout), .dout_oe_o(dout_oe), .input_connect_o(input_connect),
      .converting_o(converting), .power_down_o(power_down), .cs_mode_o(cs_mode));

   spi_host_model host (
      .cnv_o(cnv), .din_o(din), .sclk_o(sclk), .dout_i(dout), .dout_oe_i(dout_oe));

   initial sys_clk = 1'b0;
   always #4 sys_clk = ~sys_clk;

   // -----------------------------------------------------------------
   // Comparison and verdict
   // -----------------------------------------------------------------
   task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   // Input code is changed mid-conversion; the held sample must still be read
   task automatic do_convert(input logic [17:0] code, input logic mode);
      int n;
      @(posedge sys_clk);
      #1 sample_code = code;
      host.start(mode);
      n = 0;
      while (converting !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         #1 n++;
      end
      check("input_connect conv", 18'h0, {17'h0, input_connect});
      check("power_down conv", 18'h0, {17'h0, power_down});
      check("dout_oe at start", 18'h0, {17'h0, dout_oe});
      check("cs_mode", {17'h0, mode}, {17'h0, cs_mode});
      n = 0;
      while (converting === 1'b1 && n < 200) begin
         @(posedge sys_clk);
         #1 n++;
         if (n == 3) sample_code = ~code;
      end
      check("convert cycles", 18'(CONV_LEN_TB + 1), 18'(n));
      check("input_connect acq", 18'h1, {17'h0, input_connect});
      check("power_down acq", 18'h1, {17'h0, power_down});
   endtask

   task automatic t_reset();
      check("reset outputs", 18'h0c, {13'h0, dout_oe, input_connect, power_down,
                                      converting, cs_mode} ^ 18'h1);
   endtask

   task automatic t_three_wire(input logic [17:0] code);
      do_convert(code, 1'b1);
      host.frame(1'b1, 18, d);
      check("three wire data", code, d);
      check("oe after last fall", 18'h0, {17'h0, dout_oe});
   endtask

   task automatic t_four_wire();
      do_convert(18'h15a3c, 1'b1);
      host.frame(1'b0, 18, d);
      check("four wire data", 18'h15a3c, d);
      check("oe after last fall", 18'h0, {17'h0, dout_oe});
      host.deselect();
   endtask

   task automatic t_abort();
      do_convert(18'h20001, 1'b1);
      host.frame(1'b0, 5, d);
      check("partial data", 18'(5'h10), 18'(d[17:13]));
      host.deselect();
      #40 check("oe after deselect", 18'h0, {17'h0, dout_oe});
   endtask

   task automatic t_daisy();
      do_convert(18'h0f0f0, 1'b0);
      host.frame(1'b1, 18, d);
      check("daisy output off", {18{1'bx}}, d);
   endtask

   initial begin
      error_cnt = 0;
      checked = 0;
      reset = 1'b1;
      sample_code = 18'h0;
      repeat (2) @(posedge sys_clk);
      #1 reset = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      t_reset();
      t_three_wire(18'h2a5c3);
      t_four_wire();
      t_abort();
      t_daisy();
      t_three_wire(18'h3fffe);
      report_and_stop();
   end

   // Whole run needs about 10 us
   initial begin
      #100000;
      error_cnt++;
      $display("watchdog expired");
      report_and_stop();
   end
endmodule
